// File: logic/bbxu_exec.sv
// Execute unit for relative jump, bit force and bit test skip.
// Assumes the instruction word and incremented PC are valid in phase one,
// and that read data returns by the end of phase two.
`timescale 1ns/1ps
`default_nettype none
`include "bbxu_defines.svh"

module bbxu_exec (
   input wire logic i_clk_sys,
   input wire logic i_srst,
   input wire logic i_instr_valid,
   input wire logic [15:0] i_instr,
   input wire logic [`BBXU_PC_W-1:0] i_pc_inc,
   input wire logic [`BBXU_BANK_W-1:0] i_bank_selector,
   input wire logic i_ext_set_en,
   input wire logic [`BBXU_ADDR_W-1:0] i_index_base,
   input wire logic [7:0] i_rd_data,
   input wire logic i_next_two_word,
   output var bbxu_pkg::bbxu_mem_t o_mem,
   output var bbxu_pkg::bbxu_phase_t o_phase,
   output logic o_pc_load,
   output logic [`BBXU_PC_W-1:0] o_pc_target,
   output logic o_discard,
   output logic o_nop_cycle,
   output logic o_indexed,
   output logic o_status_we
);

   // ----------------------------------------
   // State
   // ----------------------------------------
   bbxu_pkg::bbxu_phase_t ph_q;       // Current phase
   bbxu_pkg::bbxu_op_t op_q;          // Operation in execution
   bbxu_pkg::bbxu_mem_t mem_q;        // Memory request
   logic [2:0] bit_q;                 // Bit index
   logic [10:0] n_q;                  // Jump offset
   logic [`BBXU_PC_W-1:0] pc_q;       // Incremented PC
   logic [7:0] rd_q;                  // Sampled register data
   logic [1:0] pend_q;                // NOP cycles owed after this one
   logic [1:0] nops_q;                // NOP cycles left
   logic nop_cycle_q;                 // Current cycle is a NOP
   logic pc_load_q;
   logic [`BBXU_PC_W-1:0] target_q;
   logic discard_q;
   logic indexed_q;
   logic status_we_q;

   // ----------------------------------------
   // Decode helpers
   // ----------------------------------------
   logic take;                        // Accept a new word in phase one
   logic skip_hit;                    // Bit test condition met
   bbxu_pkg::bbxu_op_t op_d;
   logic idx_d;
   logic [`BBXU_ADDR_W-1:0] addr_d;
   logic [`BBXU_PC_W-1:0] jump_tgt;

   assign take = i_instr_valid && (nops_q == 2'h0);

   // Opcode field match
   always_comb begin
      if (i_instr[15:11] == `BBXU_OPC_JUMP) begin
         op_d = bbxu_pkg::BBXU_OP_JUMP;
      end else if (i_instr[15:12] == `BBXU_OPC_FORCE) begin
         op_d = bbxu_pkg::BBXU_OP_FORCE;
      end else if (i_instr[15:12] == `BBXU_OPC_SKZ) begin
         op_d = bbxu_pkg::BBXU_OP_SKIP_ZERO;
      end else if (i_instr[15:12] == `BBXU_OPC_SKO) begin
         op_d = bbxu_pkg::BBXU_OP_SKIP_ONE;
      end else begin
         op_d = bbxu_pkg::BBXU_OP_NONE;
      end
   end

   // Operand address: indexed, banked or access bank
   always_comb begin
      idx_d = !i_instr[8] && i_ext_set_en && (i_instr[7:0] <= `BBXU_IDX_LIMIT);
      if (idx_d) begin
         addr_d = i_index_base + {6'h00, i_instr[7:0]};
      end else if (i_instr[8]) begin
         addr_d = {i_bank_selector, i_instr[7:0]};
      end else if (i_instr[7:0] <= `BBXU_IDX_LIMIT) begin
         addr_d = {`BBXU_ACC_LO_BANK, i_instr[7:0]};
      end else begin
         addr_d = {`BBXU_ACC_HI_BANK, i_instr[7:0]};
      end
   end

   // Sign-extended word offset doubled
   assign jump_tgt = pc_q + {{(`BBXU_PC_W-12){n_q[10]}}, n_q, 1'b0};

   // Bit test against sampled data
   assign skip_hit = ((op_q == bbxu_pkg::BBXU_OP_SKIP_ZERO) && !rd_q[bit_q]) ||
                     ((op_q == bbxu_pkg::BBXU_OP_SKIP_ONE) && rd_q[bit_q]);

   // ----------------------------------------
   // Phase sequencer
   // ----------------------------------------
   always_ff @(posedge i_clk_sys) begin
      if (i_srst) begin
         ph_q <= bbxu_pkg::BBXU_PH_Q1;
      end else begin
         unique case (ph_q)
            bbxu_pkg::BBXU_PH_Q1: ph_q <= bbxu_pkg::BBXU_PH_Q2;
            bbxu_pkg::BBXU_PH_Q2: ph_q <= bbxu_pkg::BBXU_PH_Q3;
            bbxu_pkg::BBXU_PH_Q3: ph_q <= bbxu_pkg::BBXU_PH_Q4;
            bbxu_pkg::BBXU_PH_Q4: ph_q <= bbxu_pkg::BBXU_PH_Q1;
         endcase
      end
   end

   // ----------------------------------------
   // Decode latch at end of phase one
   // ----------------------------------------
   always_ff @(posedge i_clk_sys) begin
      if (i_srst) begin
         op_q <= bbxu_pkg::BBXU_OP_NONE;
         bit_q <= 3'h0;
         n_q <= 11'h000;
         pc_q <= '0;
         indexed_q <= 1'b0;
      end else if (ph_q == bbxu_pkg::BBXU_PH_Q1) begin
         // NOP cycles latch no operation
         op_q <= take ? op_d : bbxu_pkg::BBXU_OP_NONE;
         bit_q <= i_instr[11:9];
         n_q <= i_instr[10:0];
         pc_q <= i_pc_inc;
         indexed_q <= take && (op_d != bbxu_pkg::BBXU_OP_JUMP) &&
                      (op_d != bbxu_pkg::BBXU_OP_NONE) && idx_d;
      end
   end

   // ----------------------------------------
   // Memory read, modify and write
   // ----------------------------------------
   always_ff @(posedge i_clk_sys) begin
      if (i_srst) begin
         mem_q <= '0;
         rd_q <= 8'h00;
      end else begin
         unique case (ph_q)
            bbxu_pkg::BBXU_PH_Q1: begin
               // Read in phase two for register operands
               mem_q.re <= take && (op_d != bbxu_pkg::BBXU_OP_JUMP) &&
                           (op_d != bbxu_pkg::BBXU_OP_NONE);
               mem_q.addr <= addr_d;
            end
            bbxu_pkg::BBXU_PH_Q2: begin
               mem_q.re <= 1'b0;
               rd_q <= i_rd_data;
            end
            bbxu_pkg::BBXU_PH_Q3: begin
               // Modified byte written in phase four
               mem_q.we <= (op_q == bbxu_pkg::BBXU_OP_FORCE);
               mem_q.wdata <= rd_q | (8'h01 << bit_q);
            end
            bbxu_pkg::BBXU_PH_Q4: begin
               mem_q.we <= 1'b0;
            end
         endcase
      end
   end

   // ----------------------------------------
   // PC load and fetch discard in phase four
   // ----------------------------------------
   always_ff @(posedge i_clk_sys) begin
      if (i_srst) begin
         pc_load_q <= 1'b0;
         target_q <= '0;
         discard_q <= 1'b0;
         pend_q <= 2'h0;
      end else if (ph_q == bbxu_pkg::BBXU_PH_Q3) begin
         pc_load_q <= (op_q == bbxu_pkg::BBXU_OP_JUMP);
         target_q <= jump_tgt;
         discard_q <= (op_q == bbxu_pkg::BBXU_OP_JUMP) || skip_hit;
         if (op_q == bbxu_pkg::BBXU_OP_JUMP) begin
            pend_q <= `BBXU_JUMP_NOPS;
         end else if (skip_hit) begin
            pend_q <= i_next_two_word ? `BBXU_SKIP2_NOPS : `BBXU_SKIP_NOPS;
         end else begin
            pend_q <= 2'h0;
         end
      end else begin
         pc_load_q <= 1'b0;
         discard_q <= 1'b0;
      end
   end

   // ----------------------------------------
   // NOP cycle counter, stepped at end of phase four
   // ----------------------------------------
   always_ff @(posedge i_clk_sys) begin
      if (i_srst) begin
         nops_q <= 2'h0;
         nop_cycle_q <= 1'b0;
      end else if (ph_q == bbxu_pkg::BBXU_PH_Q4) begin
         if (nops_q != 2'h0) begin
            nops_q <= nops_q - 2'h1;
            nop_cycle_q <= (nops_q != 2'h1);
         end else begin
            nops_q <= pend_q;
            nop_cycle_q <= (pend_q != 2'h0);
         end
      end
   end

   // Arithmetic flags are never written by these operations
   always_ff @(posedge i_clk_sys) begin
      status_we_q <= 1'b0;
   end

   // ----------------------------------------
   // Outputs
   // ----------------------------------------
   assign o_mem = mem_q;
   assign o_phase = ph_q;
   assign o_pc_load = pc_load_q;
   assign o_pc_target = target_q;
   assign o_discard = discard_q;
   assign o_nop_cycle = nop_cycle_q;
   assign o_indexed = indexed_q;
   assign o_status_we = status_we_q;

   // ----------------------------------------
   // Assertions
   // ----------------------------------------
   default clocking cb @(posedge i_clk_sys); endclocking
   default disable iff (i_srst);

   sequence s_q1_take(logic [3:0] opc);
      ph_q == bbxu_pkg::BBXU_PH_Q1 && take && i_instr[15:12] == opc;
   endsequence
   sequence s_rmw;
      o_mem.re ##1 !o_mem.re ##1 o_mem.we ##1 !o_mem.we;
   endsequence

   property p_jump_decode;
      ph_q == bbxu_pkg::BBXU_PH_Q1 && take && i_instr[15:11] == 5'h1a
         |=> op_q == bbxu_pkg::BBXU_OP_JUMP && n_q == $past(i_instr[10:0]);
   endproperty
   a_jump_decode: assert property (p_jump_decode) else $error("jump not decoded");
   property p_jump_target;
      ph_q == bbxu_pkg::BBXU_PH_Q3 && op_q == bbxu_pkg::BBXU_OP_JUMP
         |=> o_pc_load && $signed(o_pc_target - pc_q) == 2 * $signed(n_q);
   endproperty
   a_jump_target: assert property (p_jump_target) else $error("bad jump target");
   property p_jump_cycles;
      ph_q == bbxu_pkg::BBXU_PH_Q3 && op_q == bbxu_pkg::BBXU_OP_JUMP
         |=> ##1 o_nop_cycle[*4] ##1 !o_nop_cycle;
   endproperty
   a_jump_cycles: assert property (p_jump_cycles) else $error("jump not two cycles");
   property p_no_flags;
      !o_status_we;
   endproperty
   a_no_flags: assert property (p_no_flags) else $error("flags written");
   property p_force_data;
      ph_q == bbxu_pkg::BBXU_PH_Q3 && op_q == bbxu_pkg::BBXU_OP_FORCE
         |=> o_mem.we && o_mem.wdata[bit_q] && (o_mem.wdata | (8'h01 << bit_q)) ==
             (rd_q | (8'h01 << bit_q)) && ((o_mem.wdata ^ rd_q) & ~(8'h01 << bit_q)) == 8'h00;
   endproperty
   a_force_data: assert property (p_force_data) else $error("bad force data");
   property p_force_decode;
      s_q1_take(4'h8) |=> op_q == bbxu_pkg::BBXU_OP_FORCE && bit_q == $past(i_instr[11:9]);
   endproperty
   a_force_decode: assert property (p_force_decode) else $error("force not decoded");
   property p_bank_addr;
      s_q1_take(4'h8) and i_instr[8]
         |=> o_mem.addr == {$past(i_bank_selector), $past(i_instr[7:0])};
   endproperty
   a_bank_addr: assert property (p_bank_addr) else $error("bad banked address");
   property p_indexed;
      s_q1_take(4'h8) and !i_instr[8] && i_ext_set_en && i_instr[7:0] <= 8'h5f
         |=> o_indexed && o_mem.addr == $past(i_index_base) + $past({6'h00, i_instr[7:0]});
   endproperty
   a_indexed: assert property (p_indexed) else $error("indexed mode missed");
   property p_force_rmw;
      s_q1_take(4'h8) |=> s_rmw;
   endproperty
   a_force_rmw: assert property (p_force_rmw) else $error("bad force sequence");
   property p_skip_one;
      ph_q == bbxu_pkg::BBXU_PH_Q3 && skip_hit && !i_next_two_word
         |=> o_discard ##1 o_nop_cycle[*4] ##1 !o_nop_cycle;
   endproperty
   a_skip_one: assert property (p_skip_one) else $error("skip not one NOP");
   property p_skip_two;
      ph_q == bbxu_pkg::BBXU_PH_Q3 && skip_hit && i_next_two_word
         |=> o_discard ##1 o_nop_cycle[*8] ##1 !o_nop_cycle;
   endproperty
   a_skip_two: assert property (p_skip_two) else $error("skip not two NOPs");
endmodule
`default_nettype wire

// File: logic/bbxu_defines.svh
// Constants for the relative jump / bit force / bit test execute unit.
// Assumes a 16-bit instruction word and a 14-bit banked data address.
`ifndef BBXU_DEFINES_SVH
`define BBXU_DEFINES_SVH

// ----------------------------------------
// Widths
// ----------------------------------------
`define BBXU_PC_W 21
`define BBXU_ADDR_W 14
`define BBXU_BANK_W 6

// ----------------------------------------
// Opcode fields
// ----------------------------------------
`define BBXU_OPC_JUMP 5'h1a
`define BBXU_OPC_FORCE 4'h8
`define BBXU_OPC_SKZ 4'hb
`define BBXU_OPC_SKO 4'ha

// ----------------------------------------
// Addressing
// ----------------------------------------
`define BBXU_IDX_LIMIT 8'h5f
`define BBXU_ACC_LO_BANK 6'h00
`define BBXU_ACC_HI_BANK 6'h3f

// ----------------------------------------
// Added NOP cycles
// ----------------------------------------
`define BBXU_JUMP_NOPS 2'h1
`define BBXU_SKIP_NOPS 2'h1
`define BBXU_SKIP2_NOPS 2'h2

`endif

// File: logic/bbxu_pkg.sv
// Types shared by the execute unit.
// Assumes the defines header is on the include path.
`default_nettype none
`include "bbxu_defines.svh"

package bbxu_pkg;
   // ----------------------------------------
   // Decoded operation
   // ----------------------------------------
   typedef enum logic [2:0] {
      BBXU_OP_NONE,
      BBXU_OP_JUMP,
      BBXU_OP_FORCE,
      BBXU_OP_SKIP_ZERO,
      BBXU_OP_SKIP_ONE
   } bbxu_op_t;

   // ----------------------------------------
   // Four phases of one instruction cycle
   // ----------------------------------------
   typedef enum logic [1:0] {
      BBXU_PH_Q1,
      BBXU_PH_Q2,
      BBXU_PH_Q3,
      BBXU_PH_Q4
   } bbxu_phase_t;

   // ----------------------------------------
   // Data memory request
   // ----------------------------------------
   typedef struct packed {
      logic re;                          // Read strobe, phase two
      logic we;                          // Write strobe, phase four
      logic [`BBXU_ADDR_W-1:0] addr;     // Banked data address
      logic [7:0] wdata;                 // Write data
   } bbxu_mem_t;
endpackage
`default_nettype wire

// File: testbench/test_branch_bitset_exec_unit.sv
// Self-checking bench for the jump / bit force / bit test execute unit.
// Assumes the unit and its package and defines header are compiled first.
`timescale 1ns/1ps
`default_nettype none
`include "bbxu_defines.svh"

module test_branch_bitset_exec_unit;
   // ----------------------------------------
   // Stimulus and observed signals
   // ----------------------------------------
   logic i_clk_sys = 1'b0; // System clock
   logic i_srst = 1'b1; // Synchronous reset
   logic i_instr_valid = 1'b0; // Word offered
   logic [15:0] i_instr = 16'h0000; // Instruction word
   logic [`BBXU_PC_W-1:0] i_pc_inc = 21'h000000; // Incremented PC
   logic [`BBXU_BANK_W-1:0] i_bank_selector = 6'h2a; // Bank selector
   logic i_ext_set_en = 1'b0; // Extended set on
   logic [`BBXU_ADDR_W-1:0] i_index_base = 14'h3fb0; // Index base, wraps
   logic [7:0] i_rd_data = 8'h00; // Register read data
   logic i_next_two_word = 1'b0; // Next word is two-word
   bbxu_pkg::bbxu_mem_t o_mem; // Memory request
   bbxu_pkg::bbxu_phase_t o_phase; // Current phase
   logic o_pc_load, o_discard, o_nop_cycle, o_indexed, o_status_we;
   logic [`BBXU_PC_W-1:0] o_pc_target; // Jump target
   integer err_count = 0; // Mismatches
   integer n_tests = 0; // Comparisons

   bbxu_exec bbxu_exec_inst (
      .i_clk_sys(i_clk_sys), .i_srst(i_srst), .i_instr_valid(i_instr_valid),
      .i_instr(i_instr), .i_pc_inc(i_pc_inc), .i_bank_selector(i_bank_selector),
      .i_ext_set_en(i_ext_set_en), .i_index_base(i_index_base),
      .i_rd_data(i_rd_data), .i_next_two_word(i_next_two_word), .o_mem(o_mem),
      .o_phase(o_phase), .o_pc_load(o_pc_load), .o_pc_target(o_pc_target),
      .o_discard(o_discard), .o_nop_cycle(o_nop_cycle), .o_indexed(o_indexed),
      .o_status_we(o_status_we)
   );

   // 50 MHz clock
   initial begin
      forever #10 i_clk_sys = ~i_clk_sys;
   end

   // ----------------------------------------
   // Shared tasks
   // ----------------------------------------
   // Verdict and end of run
   task automatic complete_run;
      begin
         $display("Comparisons %0d, mismatches %0d", n_tests, err_count);
         if (err_count == 0 && n_tests > 0) begin
            $display("STATUS OK");
         end else begin
            $display("STATUS NOT OK");
         end
         $finish;
      end
   endtask

   // Compare one value
   task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string msg);
      begin
         n_tests++;
         if (got !== exp) begin
            err_count++;
            $display("[FAIL] %0t %s got %h exp %h", $time, msg, got, exp);
         end
      end
   endtask

   // Issue one word in Q1 and judge the whole cycle plus inserted NOPs
   task automatic exec(input logic [15:0] w, input logic [7:0] rd, input logic two,
         input logic re, input logic [13:0] addr, input logic idx, input logic we,
         input logic [7:0] wd, input logic jmp, input logic [20:0] tgt,
         input logic disc, input integer nops);
      integer k;
      integer nc;
      begin
         k = 0;
         while (o_phase !== bbxu_pkg::BBXU_PH_Q1 && k < 16) begin
            @(negedge i_clk_sys);
            k++;
         end
         i_instr = w;
         i_instr_valid = 1'b1;
         i_next_two_word = two;
         @(negedge i_clk_sys);
         i_instr_valid = 1'b0;
         i_rd_data = rd;
         chk(o_phase, bbxu_pkg::BBXU_PH_Q2, "phase q2");
         chk(o_mem.re, re, "read strobe");
         if (re) begin
            chk(o_mem.addr, addr, "address");
         end
         chk(o_indexed, idx, "indexed");
         @(negedge i_clk_sys);
         chk(o_mem.re, 1'b0, "read strobe q3");
         @(negedge i_clk_sys);
         chk(o_mem.we, we, "write strobe q4");
         if (we) begin
            chk(o_mem.wdata, wd, "write data");
         end
         chk(o_pc_load, jmp, "pc load");
         if (jmp) begin
            chk(o_pc_target, tgt, "target");
         end
         chk(o_discard, disc, "discard");
         nc = 0;
         for (k = 0; k < 12; k++) begin
            @(negedge i_clk_sys);
            chk(o_status_we, 1'b0, "flag write");
            if (k == 0) begin
               chk({o_mem.we, o_pc_load, o_discard}, 3'h0, "pulse length");
            end
            if (o_nop_cycle === 1'b1) begin
               nc++;
               chk({o_mem.re, o_mem.we, o_pc_load}, 3'h0, "nop activity");
            end
            // Offer the word again in each NOP cycle's Q1; it must be ignored
            i_instr_valid = (o_nop_cycle === 1'b1) && (o_phase === bbxu_pkg::BBXU_PH_Q1);
         end
         chk(nc, nops * 4, "nop clocks");
      end
   endtask

   // ----------------------------------------
   // Scenarios
   // ----------------------------------------
   // Outputs right after reset release
   task automatic t_reset;
      begin
         // Still the reset state in the step of release
         chk(o_phase, bbxu_pkg::BBXU_PH_Q1, "reset phase");
         chk({o_mem, o_pc_load, o_discard, o_nop_cycle, o_indexed, o_status_we}, 29'h0,
            "reset outs");
         // First edge after release steps the phase, outputs stay idle
         @(negedge i_clk_sys);
         chk(o_phase, bbxu_pkg::BBXU_PH_Q2, "phase after release");
         chk({o_mem, o_pc_load, o_discard, o_nop_cycle, o_indexed, o_status_we}, 29'h0,
            "idle outs");
      end
   endtask

   // Jump at both offset extremes, plus a near miss of the opcode
   task automatic t_jump;
      logic [10:0] n;
      begin
         i_pc_inc = 21'h000100;
         n = 11'h400;
         exec({5'h1a, n}, 8'h00, 1'b0, 1'b0, 14'h0, 1'b0, 1'b0, 8'h0, 1'b1,
            21'h1ff900, 1'b1, 1);
         i_pc_inc = 21'h1ffffe;
         n = 11'h3ff;
         exec({5'h1a, n}, 8'h00, 1'b0, 1'b0, 14'h0, 1'b0, 1'b0, 8'h0, 1'b1,
            21'h0007fc, 1'b1, 1);
         exec(16'hd800, 8'h00, 1'b0, 1'b0, 14'h0, 1'b0, 1'b0, 8'h0, 1'b0,
            21'h0, 1'b0, 0);
      end
   endtask

   // Bit force on every bit index through the bank selector
   task automatic t_force;
      logic [2:0] b;
      integer i;
      begin
         for (i = 0; i < 8; i++) begin
            b = i[2:0];
            exec({4'h8, b, 1'b1, 5'h10, b}, 8'h0a, 1'b0, 1'b1,
               {i_bank_selector, 5'h10, b}, 1'b0, 1'b1, 8'h0a | (8'h01 << b),
               1'b0, 21'h0, 1'b0, 0);
         end
      end
   endtask

   // Access bank and indexed modes at the 0x5f boundary
   task automatic t_addr;
      begin
         i_ext_set_en = 1'b1;
         exec(16'h8e5f, 8'h00, 1'b0, 1'b1, i_index_base + 14'h005f, 1'b1, 1'b1,
            8'h80, 1'b0, 21'h0, 1'b0, 0);
         exec(16'h8060, 8'h00, 1'b0, 1'b1, 14'h3f60, 1'b0, 1'b1, 8'h01, 1'b0,
            21'h0, 1'b0, 0);
         i_ext_set_en = 1'b0;
         exec(16'h8200, 8'hff, 1'b0, 1'b1, 14'h0000, 1'b0, 1'b1, 8'hff, 1'b0,
            21'h0, 1'b0, 0);
      end
   endtask

   // Bit test skips, taken over one and two words, and not taken
   task automatic t_skip;
      begin
         exec(16'hb712, 8'hf7, 1'b1, 1'b1, {i_bank_selector, 8'h12}, 1'b0, 1'b0,
            8'h0, 1'b0, 21'h0, 1'b1, 2);
         exec(16'ha512, 8'h04, 1'b0, 1'b1, {i_bank_selector, 8'h12}, 1'b0, 1'b0,
            8'h0, 1'b0, 21'h0, 1'b1, 1);
         exec(16'ha512, 8'hfb, 1'b1, 1'b1, {i_bank_selector, 8'h12}, 1'b0, 1'b0,
            8'h0, 1'b0, 21'h0, 1'b0, 0);
      end
   endtask

   // ----------------------------------------
   // Main sequence and watchdog
   // ----------------------------------------
   initial begin
      repeat (5) @(negedge i_clk_sys);
      i_srst = 1'b0;
      t_reset;
      t_jump;
      t_force;
      t_addr;
      t_skip;
      complete_run;
   end

   // Cut a hang well past the expected few hundred clocks
   initial begin
      #(20 * 3000);
      err_count++;
      complete_run;
   end
endmodule
`default_nettype wire
